// ### verilog/erfs_defs.vh
`ifndef ERFS_DEFS_VH
`define ERFS_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ERFS_OFF_STATUS 8'h00
`define ERFS_OFF_MASK 8'h04
`define ERFS_OFF_CTRL 8'h08
`define ERFS_OFF_MAXLEN 8'h0C
`define ERFS_OFF_LAST 8'h10

// ****************************************************************
// status bit positions
// ****************************************************************
`define ERFS_B_DESC_ERR 14
`define ERFS_B_PSTOP 13
`define ERFS_B_NOBUF 12
`define ERFS_B_MII_ERR 11
`define ERFS_B_JABBER 10
`define ERFS_B_ALIGN 9
`define ERFS_B_CRC 8
`define ERFS_B_UNDS 7
`define ERFS_B_FRAG 6
`define ERFS_B_LONG 5
`define ERFS_B_UCAST 4
`define ERFS_B_MCAST 3
`define ERFS_B_BCAST 2
`define ERFS_B_OVERF 1
`define ERFS_B_DONE 0

// ****************************************************************
// control fields and reset values
// ****************************************************************
`define ERFS_CTRL_EN 0
`define ERFS_CTRL_RESUME 1
`define ERFS_STATUS_RST 15'h0000
`define ERFS_MASK_RST 15'h0000
`define ERFS_CTRL_RST 1'b0
`define ERFS_MAXLEN_RST 16'h0000

// ****************************************************************
// frame constants
// ****************************************************************
`define ERFS_MIN_FRAME 16'h0040
`define ERFS_MAX_FRAME_DEF 16'h05EE
`define ERFS_DA_LEN 16'h0006
`define ERFS_SFD_NIB 4'hD
`define ERFS_CRC_INIT 32'hFFFFFFFF
`define ERFS_CRC_POLY 32'hEDB88320
`define ERFS_CRC_RESIDUE 32'hDEBB20E3

`endif

// ### verilog/erfs_rx_status.v
// Summary of operation
// - no room, host owns next: truncate, flag 14
// - reception suspended sets stopped flag 13
// - host-owned next descriptor: suspend, flag 12
// - rx error while data valid sets 11
// - rx error forces crc flag, counts bad
// - over maximum with bad crc sets 10
// - alignment error, bad crc, 64+ sets 9
// - 64 bytes or more, bad crc sets 8
// - under 64 bytes, good crc sets 7
// - under 64 bytes, bad crc sets 6
// - over maximum with good crc sets 5
// - unicast destination sets bit 4
// - multicast destination sets bit 3
// - broadcast destination sets bit 2
// - byte dropped on a full fifo sets 1
// - frame complete sets 0, posts status
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "erfs_defs.vh"

module erfs_rx_status #(
  parameter [15:0] MAX_FRAME = `ERFS_MAX_FRAME_DEF
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire mii_rx_clk,
  input wire mii_receive_valid_in,
  input wire mii_receive_error_in,
  input wire [3:0] mii_rxd,
  input wire next_desc_mac_owned,
  input wire [15:0] buf_space,
  input wire fifo_full,
  output reg [7:0] rx_byte_data,
  output reg rx_byte_valid,
  output reg [15:0] frame_status,
  output reg frame_status_valid,
  output reg crc_count_inc,
  output reg rx_suspended,
  output wire irq
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_PRE = 2'b01;
  localparam [1:0] ST_DATA = 2'b10;
  localparam [1:0] ST_DROP = 2'b11;

  // ****************************************************************
  // crc over one byte, lsb first
  // ****************************************************************
  function [31:0] erfs_crc_byte;
    input [31:0] c;
    input [7:0] d;
    integer i;
    reg [31:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (r[0] ^ d[i])
          r = (r >> 1) ^ `ERFS_CRC_POLY;
        else
          r = r >> 1;
      end
      erfs_crc_byte = r;
    end
  endfunction

  // ****************************************************************
  // register offset match on the low address byte
  // ****************************************************************
  function erfs_hit;
    input [7:0] a;
    input [7:0] off;
    begin
      erfs_hit = (a == off);
    end
  endfunction

  // ****************************************************************
  // link input synchronisers
  // ****************************************************************
  reg lclk_s1;
  reg lclk_s2;
  reg lclk_s3;
  reg dv_s1;
  reg dv_s2;
  reg er_s1;
  reg er_s2;
  reg [3:0] rxd_s1;
  reg [3:0] rxd_s2;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lclk_s1 <= 1'b0;
      lclk_s2 <= 1'b0;
      lclk_s3 <= 1'b0;
      dv_s1 <= 1'b0;
      dv_s2 <= 1'b0;
      er_s1 <= 1'b0;
      er_s2 <= 1'b0;
      rxd_s1 <= 4'h0;
      rxd_s2 <= 4'h0;
    end else begin
      lclk_s1 <= mii_rx_clk;
      lclk_s2 <= lclk_s1;
      lclk_s3 <= lclk_s2;
      dv_s1 <= mii_receive_valid_in;
      dv_s2 <= dv_s1;
      er_s1 <= mii_receive_error_in;
      er_s2 <= er_s1;
      rxd_s1 <= mii_rxd;
      rxd_s2 <= rxd_s1;
    end
  end

  // ****************************************************************
  // link clock edge
  // ****************************************************************
  // data and valid pass the same two stages, so they are settled here
  wire lclk_rise = lclk_s2 & ~lclk_s3;

  // ****************************************************************
  // register bus
  // ****************************************************************
  reg [14:0] status;
  reg [14:0] mask;
  reg rx_enable;
  reg [15:0] cfg_max;
  reg wr_pend;
  reg [7:0] wr_addr;
  wire acc = hsel & htrans[1] & hready;

  // zero wait states: every access completes in its data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(status & mask);

  wire wr_status = wr_pend && erfs_hit(wr_addr, `ERFS_OFF_STATUS);
  wire wr_mask = wr_pend && erfs_hit(wr_addr, `ERFS_OFF_MASK);
  wire wr_ctrl = wr_pend && erfs_hit(wr_addr, `ERFS_OFF_CTRL);
  wire wr_max = wr_pend && erfs_hit(wr_addr, `ERFS_OFF_MAXLEN);

  // ****************************************************************
  // read mux
  // ****************************************************************
  reg [31:0] rd_mux;
  always @* begin
    case (haddr[7:0])
      `ERFS_OFF_STATUS: rd_mux = {17'h00000, status};
      `ERFS_OFF_MASK: rd_mux = {17'h00000, mask};
      `ERFS_OFF_CTRL: rd_mux = {31'h00000000, rx_enable};
      `ERFS_OFF_MAXLEN: rd_mux = {16'h0000, cfg_max};
      `ERFS_OFF_LAST: rd_mux = {16'h0000, frame_status};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // register writes and read data
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      mask <= `ERFS_MASK_RST;
      rx_enable <= `ERFS_CTRL_RST;
      cfg_max <= `ERFS_MAXLEN_RST;
    end else begin
      wr_pend <= acc & hwrite;
      if (acc)
        wr_addr <= haddr[7:0];
      // read data latched at the address phase, stands in the data phase
      if (acc & ~hwrite)
        hrdata <= rd_mux;
      if (wr_mask)
        mask <= hwdata[14:0];
      if (wr_ctrl)
        rx_enable <= hwdata[`ERFS_CTRL_EN];
      if (wr_max)
        cfg_max <= hwdata[15:0];
    end
  end

  // ****************************************************************
  // frame accumulation
  // ****************************************************************
  reg [1:0] state;
  reg [15:0] byte_cnt;
  reg nib_phase;
  reg [3:0] low_nib;
  reg [31:0] crc;
  reg er_seen;
  reg truncated;
  reg overflowed;
  reg da_group;
  reg da_bcast;
  reg frame_end;
  reg suspend_ev;

  // ****************************************************************
  // frame classification
  // ****************************************************************
  wire [15:0] lim = (cfg_max != 16'h0000) ? cfg_max : MAX_FRAME;
  wire bad = (crc != `ERFS_CRC_RESIDUE) | er_seen;
  wire runt = byte_cnt < `ERFS_MIN_FRAME;
  wire over = byte_cnt > lim;
  wire da_ok = byte_cnt >= `ERFS_DA_LEN;

  reg [15:0] fs;
  always @* begin
    fs = 16'h0000;
    fs[`ERFS_B_DESC_ERR] = truncated;
    fs[`ERFS_B_MII_ERR] = er_seen;
    fs[`ERFS_B_JABBER] = over & bad;
    fs[`ERFS_B_ALIGN] = nib_phase & bad & ~runt;
    fs[`ERFS_B_CRC] = (~runt & bad) | er_seen;
    fs[`ERFS_B_UNDS] = runt & ~bad;
    fs[`ERFS_B_FRAG] = runt & bad;
    fs[`ERFS_B_LONG] = over & ~bad;
    fs[`ERFS_B_UCAST] = da_ok & ~da_group;
    fs[`ERFS_B_MCAST] = da_ok & da_group & ~da_bcast;
    fs[`ERFS_B_BCAST] = da_ok & da_bcast;
    fs[`ERFS_B_OVERF] = overflowed;
    fs[`ERFS_B_DONE] = 1'b1;
  end

  // ****************************************************************
  // nibble assembly
  // ****************************************************************
  // high nibble arrives second; the low one was held from the edge before
  wire [7:0] cur_byte = {rxd_s2, low_nib};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      byte_cnt <= 16'h0000;
      nib_phase <= 1'b0;
      low_nib <= 4'h0;
      crc <= `ERFS_CRC_INIT;
      er_seen <= 1'b0;
      truncated <= 1'b0;
      overflowed <= 1'b0;
      da_group <= 1'b0;
      da_bcast <= 1'b1;
      frame_end <= 1'b0;
      rx_byte_data <= 8'h00;
      rx_byte_valid <= 1'b0;
    end else begin
      frame_end <= 1'b0;
      rx_byte_valid <= 1'b0;
      if (lclk_rise) begin
        if (dv_s2 & er_s2 & (state != ST_DROP))
          er_seen <= 1'b1;
        case (state)
          ST_IDLE: begin
            byte_cnt <= 16'h0000;
            nib_phase <= 1'b0;
            crc <= `ERFS_CRC_INIT;
            er_seen <= dv_s2 & er_s2 & rx_enable & ~rx_suspended;
            truncated <= 1'b0;
            overflowed <= 1'b0;
            da_group <= 1'b0;
            da_bcast <= 1'b1;
            if (dv_s2) begin
              if (rx_enable & ~rx_suspended)
                state <= ST_PRE;
              else
                state <= ST_DROP;
            end
          end
          ST_PRE: begin
            if (!dv_s2)
              state <= ST_IDLE;
            else if (rxd_s2 == `ERFS_SFD_NIB)
              state <= ST_DATA;
          end
          ST_DATA: begin
            if (!dv_s2) begin
              frame_end <= 1'b1;
              state <= ST_IDLE;
            end else if (!nib_phase) begin
              low_nib <= rxd_s2;
              nib_phase <= 1'b1;
            end else begin
              nib_phase <= 1'b0;
              crc <= erfs_crc_byte(crc, cur_byte);
              if (byte_cnt != 16'hFFFF)
                byte_cnt <= byte_cnt + 16'h0001;
              if (byte_cnt == 16'h0000)
                da_group <= cur_byte[0];
              if ((byte_cnt < `ERFS_DA_LEN) && (cur_byte != 8'hFF))
                da_bcast <= 1'b0;
              // once truncated, the rest of the frame is discarded
              if (truncated |
                  ((byte_cnt >= buf_space) & ~next_desc_mac_owned)) begin
                truncated <= 1'b1;
              end else if (fifo_full) begin
                overflowed <= 1'b1;
              end else begin
                rx_byte_data <= cur_byte;
                rx_byte_valid <= 1'b1;
              end
            end
          end
          ST_DROP: begin
            if (!dv_s2)
              state <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // completion, suspension and sticky status
  // ****************************************************************
  reg [14:0] ev;
  always @* begin
    ev = 15'h0000;
    if (frame_end)
      ev = fs[14:0];
    if (suspend_ev) begin
      ev[`ERFS_B_NOBUF] = 1'b1;
      ev[`ERFS_B_PSTOP] = 1'b1;
    end
  end

  // ****************************************************************
  // sticky status
  // ****************************************************************
  // write-one clear mask for the sticky bits
  wire [14:0] clr = wr_status ? hwdata[14:0] : 15'h0000;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_status <= 16'h0000;
      frame_status_valid <= 1'b0;
      crc_count_inc <= 1'b0;
      rx_suspended <= 1'b0;
      suspend_ev <= 1'b0;
      status <= `ERFS_STATUS_RST;
    end else begin
      frame_status_valid <= frame_end;
      crc_count_inc <= frame_end & fs[`ERFS_B_CRC];
      // suspension is decided only once a frame has ended
      suspend_ev <= frame_end & ~next_desc_mac_owned & ~rx_suspended;
      if (frame_end)
        frame_status <= fs;
      if (suspend_ev)
        rx_suspended <= 1'b1;
      else if (wr_ctrl & hwdata[`ERFS_CTRL_RESUME] & next_desc_mac_owned)
        rx_suspended <= 1'b0;
      // set wins over a simultaneous write-one clear
      status <= (status & ~clr) | ev;
    end
  end

endmodule
`default_nettype wire

// ### tb/erfs_mii_phy.sv
`timescale 1ns/1ps
`default_nettype none
module erfs_mii_phy (
  output logic mii_rx_clk,
  output logic mii_receive_valid_in,
  output logic mii_receive_error_in,
  output logic [3:0] mii_rxd
);
  logic [7:0] fb [0:127];
  initial begin
    mii_rx_clk = 1'b0;
    mii_receive_valid_in = 1'b0;
    mii_receive_error_in = 1'b0;
    mii_rxd = 4'h0;
  end
  task automatic nib(input logic [3:0] v);
    mii_rxd = v;
    #40 mii_rx_clk = 1'b1;
    #40 mii_rx_clk = 1'b0;
  endtask
  // kind: 0 unicast, 1 multicast, 2 broadcast; bad spoils the fcs
  task automatic send(input int n, kind, input bit bad, er, odd);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < n - 4; i++) begin
      fb[i] = (i > 5) ? i[7:0] : (kind == 2) ? 8'hFF : (kind == 1) ? 8'h01
        : 8'h02;
      c = c ^ {24'h000000, fb[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    c = ~c ^ {31'h00000000, bad};
    for (int i = 0; i < 4; i++) fb[n - 4 + i] = c[8 * i +: 8];
    #13 mii_receive_valid_in = 1'b1;
    repeat (15) nib(4'h5);
    nib(4'hD);
    for (int i = 0; i < n; i++) begin
      mii_receive_error_in = er && (i == 20);
      nib(fb[i][3:0]);
      nib(fb[i][7:4]);
    end
    if (odd) nib(4'h3);
    mii_receive_valid_in = 1'b0;
    mii_receive_error_in = 1'b0;
    // released data lines keep toggling so no stale nibble is seen
    repeat (3) nib(~mii_rxd);
  endtask
endmodule
`default_nettype wire

// ### tb/erfs_rx_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module erfs_rx_status_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [15:0] frame_status,
  input wire logic frame_status_valid,
  input wire logic crc_count_inc,
  input wire logic rx_suspended,
  input wire logic rx_byte_valid
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_post;
    frame_status_valid ##1 !frame_status_valid;
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_post_pulse: assert property (frame_status_valid |-> s_post)
    else $error("status post not a single pulse");
  chk_done_bit: assert property (frame_status_valid |-> frame_status[0])
    else $error("done bit missing");
  chk_crc_count: assert property (crc_count_inc == (frame_status_valid && frame_status[8]))
    else $error("bad crc count pulse wrong");
  chk_mii_crc: assert property (frame_status_valid && frame_status[11] |-> frame_status[8])
    else $error("rx error without crc flag");
  chk_size_class: assert property (frame_status_valid
    && !frame_status[11] |-> $onehot0(frame_status[8:6]))
    else $error("size classes overlap");
  chk_align_crc: assert property (frame_status_valid && frame_status[9] |-> frame_status[8])
    else $error("alignment without crc flag");
  chk_long_class: assert property (frame_status_valid |-> !(frame_status[10] && frame_status[5]))
    else $error("jabber and long both set");
  chk_dest_class: assert property (frame_status_valid |-> $onehot0(frame_status[4:2]))
    else $error("destination classes overlap");
  chk_suspend_cause: assert property ($rose(rx_suspended) |-> $past(frame_status_valid))
    else $error("suspension without frame end");
  chk_byte_pulse: assert property (rx_byte_valid |=> !rx_byte_valid)
    else $error("byte strobe too long");
endmodule
bind erfs_rx_status erfs_rx_status_assertions u_chk (.hclk, .hresetn,
  .hreadyout, .hresp, .frame_status, .frame_status_valid, .crc_count_inc,
  .rx_suspended, .rx_byte_valid);
`default_nettype wire

// ### tb/erfs_rx_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module erfs_rx_status_bench;
  logic hclk, hresetn, hsel, hwrite, next_desc_mac_owned, fifo_full;
  logic posted, cap_crc;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] buf_space, cap_fs, e;
  wire [31:0] hrdata;
  wire [15:0] frame_status;
  wire [3:0] mii_rxd;
  wire hreadyout, hresp, mii_rx_clk, mii_receive_valid_in;
  wire mii_receive_error_in, frame_status_valid, crc_count_inc;
  wire rx_suspended, irq, rx_byte_valid;
  wire [7:0] rx_byte_data;
  logic [7:0] first_b;
  int err_total, check_count, cyc, byte_seen;
  int tn[8] = '{64, 64, 60, 60, 101, 101, 64, 64};
  int tk[8] = '{0, 1, 2, 0, 0, 0, 0, 0};
  bit tb[8] = '{0, 1, 0, 1, 0, 1, 0, 1};
  bit te[8] = '{0, 0, 0, 0, 0, 0, 1, 0};
  bit tod[8] = '{0, 0, 0, 0, 0, 0, 0, 1};
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  erfs_mii_phy phy (.mii_rx_clk, .mii_receive_valid_in,
    .mii_receive_error_in, .mii_rxd);
  erfs_rx_status i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .mii_rx_clk, .mii_receive_valid_in, .mii_receive_error_in, .mii_rxd,
    .next_desc_mac_owned, .buf_space, .fifo_full, .rx_byte_data,
    .rx_byte_valid, .frame_status, .frame_status_valid, .crc_count_inc,
    .rx_suspended, .irq);
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (rx_byte_valid === 1'b1) begin
      byte_seen <= byte_seen + 1;
      if (byte_seen == 0) first_b <= rx_byte_data;
    end
    if (frame_status_valid === 1'b1) begin
      cap_fs <= frame_status;
      cap_crc <= crc_count_inc;
      posted <= 1'b1;
    end
    if (cyc == 40000) begin
      err_total++;
      final_report;
    end
  end
  task final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task frame(input int n, k, input bit b, er, od);
    posted <= 1'b0;
    byte_seen <= 0;
    phy.send(n, k, b, er, od);
    @(posedge hclk);
    for (int i = 0; i < 50 && posted !== 1'b1; i++) @(posedge hclk);
  endtask
  function logic [15:0] exp_fs(input int n, k, input bit b, er, od);
    exp_fs = 16'h0001;
    exp_fs[4 - k] = 1'b1;
    b = b | er;
    if (n < 64) exp_fs[b ? 6 : 7] = 1'b1;
    else begin
      exp_fs[8] = b;
      exp_fs[9] = b & od;
      if (n > 100) exp_fs[b ? 10 : 5] = 1'b1;
    end
    exp_fs[11] = er;
  endfunction
  initial begin
    {hsel, hwrite, fifo_full, hresetn, posted} = 5'h00;
    {haddr, hwdata, htrans, cyc} = 0;
    hsize = 3'h2;
    next_desc_mac_owned = 1'b1;
    buf_space = 16'hFFFF;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a < 24; a += 4) begin
      bus(1'b0, a[7:0], 32'h00000000);
      chk("reset value", rd, 32'h00000000);
    end
    $display("test reset done");
    bus(1'b1, 8'h0C, 32'h00000064);
    bus(1'b1, 8'h04, 32'h00000001);
    bus(1'b1, 8'h08, 32'h00000001);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'h00, 32'h00007FFF);
      #1 chk("irq cleared", irq, 1'b0);
      frame(tn[i], tk[i], tb[i], te[i], tod[i]);
      e = exp_fs(tn[i], tk[i], tb[i], te[i], tod[i]);
      chk("frame status", cap_fs, e);
      chk("crc count", cap_crc, e[8]);
      chk("bytes stored", byte_seen, tn[i]);
      chk("first byte", first_b, tk[i] == 2 ? 32'hFF : 32'h02 >> tk[i]);
      bus(1'b0, 8'h00, 32'h00000000);
      chk("status reg", rd, e);
      bus(1'b0, 8'h10, 32'h00000000);
      chk("last status", rd, e);
      #1 chk("irq raised", irq, 1'b1);
    end
    bus(1'b1, 8'h04, 32'h00000000);
    #1 chk("irq masked", irq, 1'b0);
    $display("test classes done");
    next_desc_mac_owned <= 1'b0;
    buf_space <= 16'h000A;
    bus(1'b1, 8'h00, 32'h00007FFF);
    frame(64, 0, 1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge hclk);
    bus(1'b0, 8'h00, 32'h00000000);
    chk("suspend bits", rd & 32'h7000, 32'h00007000);
    chk("suspended", rx_suspended, 1'b1);
    chk("truncated bytes", byte_seen, 10);
    frame(64, 0, 1'b0, 1'b0, 1'b0);
    chk("dropped", posted, 1'b0);
    chk("dropped bytes", byte_seen, 0);
    next_desc_mac_owned <= 1'b1;
    buf_space <= 16'hFFFF;
    bus(1'b1, 8'h08, 32'h00000003);
    repeat (2) @(posedge hclk);
    chk("resumed", rx_suspended, 1'b0);
    $display("test suspend done");
    fifo_full <= 1'b1;
    bus(1'b1, 8'h00, 32'h00007FFF);
    frame(64, 0, 1'b0, 1'b0, 1'b0);
    bus(1'b0, 8'h00, 32'h00000000);
    chk("overflow", rd[1], 1'b1);
    chk("overflow bytes", byte_seen, 0);
    fifo_full <= 1'b0;
    $display("test overflow done");
    final_report;
  end
endmodule
`default_nettype wire
